// file: ctu_pkg.sv
// Package for the 16-bit counter unit: control carrier, widths and encodings
package ctu_pkg;

	localparam int unsigned CTU_CNT_W = 16;
	localparam int unsigned CTU_BYTE_W = 8;
	localparam int unsigned CTU_PSC_W = 3;

	// Prescale select encodings: divide by 1, 2, 4 or 8
	localparam logic [1:0] CTU_DIV1 = 2'h0;
	localparam logic [1:0] CTU_DIV2 = 2'h1;
	localparam logic [1:0] CTU_DIV4 = 2'h2;
	localparam logic [1:0] CTU_DIV8 = 2'h3;

	// Prescale counter terminal values, one per ratio
	localparam logic [2:0] CTU_PSC_END1 = 3'h0;
	localparam logic [2:0] CTU_PSC_END2 = 3'h1;
	localparam logic [2:0] CTU_PSC_END4 = 3'h3;
	localparam logic [2:0] CTU_PSC_END8 = 3'h7;

	localparam logic [2:0] CTU_PSC_RST = 3'h0;
	localparam logic [15:0] CTU_CNT_RST = 16'h0000;
	localparam logic [15:0] CTU_CNT_MAX = 16'hffff;
	localparam logic [15:0] CTU_CNT_ONE = 16'h0001;

	// Timer control register contents, held as plain ports
	typedef struct packed {
		logic timer_on;          // Counter runs while set
		logic [1:0] prescale_select;
		logic secondary_osc_enable;
		logic unsync_mode;       // Set: external input not synchronised
		logic ext_source;        // Set: count the external clock
	} ctu_ctrl_s;

	// Software write of one count byte
	typedef struct packed {
		logic wr_high;
		logic wr_low;
		logic [7:0] data;
	} ctu_wr_s;

endpackage

// file: ctu_prescaler.sv
// Prescaler of the counter unit: divides input ticks by 1, 2, 4 or 8
`timescale 1ns/1ps
`default_nettype none

module ctu_prescaler (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic tick_in,
	input wire logic clear,
	input wire logic [1:0] prescale_select,
	output logic tick_out
);
	import ctu_pkg::*;

	logic [2:0] psc_q;
	logic [2:0] end_val;

	// Terminal count of the chosen ratio
	function automatic logic [2:0] psc_end(input logic [1:0] sel);
		unique case (sel)
			CTU_DIV1: psc_end = CTU_PSC_END1;
			CTU_DIV2: psc_end = CTU_PSC_END2;
			CTU_DIV4: psc_end = CTU_PSC_END4;
			CTU_DIV8: psc_end = CTU_PSC_END8;
		endcase
	endfunction

	assign end_val = psc_end(prescale_select);
	assign tick_out = tick_in && !clear && (psc_q == end_val);

	// Hidden divider; only reset or a count byte write clears it, software never sees it
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			psc_q <= CTU_PSC_RST;
		end else if (clear) begin
			psc_q <= CTU_PSC_RST;
		end else if (tick_in) begin
			if (psc_q >= end_val) begin
				psc_q <= CTU_PSC_RST;
			end else begin
				psc_q <= psc_q + 3'h1;
			end
		end
	end

endmodule

`default_nettype wire

// file: ctu_timer.sv
// Top of the counter unit: clock selection, oscillator, 16-bit count and overflow
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Input clock is divided by 1, 2, 4 or 8 per prescale select.
// - Prescale counter is hidden and cleared by any count byte write.
// - Crystal amplifier drives the crystal only while oscillator enable is set.
// - Enabled oscillator keeps running during sleep.
// - Unsynchronised mode counts external edges without the synchroniser stages.
// - Unsynchronised external counting continues in sleep; overflow wakes processor.
// - Mode switches may lose or add one increment.
// - The 16-bit count is read and written as two byte registers.
// - Byte reads always return a coherent registered value.
module ctu_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire ctu_pkg::ctu_ctrl_s ctrl,
	input wire ctu_pkg::ctu_wr_s wr,
	input wire logic overflow_clear,
	input wire logic sleep_mode,
	input wire logic ext_clk_pin,
	input wire logic crystal_input_pin,
	output logic crystal_drive_pin,
	output logic [7:0] count_high_byte,
	output logic [7:0] count_low_byte,
	output logic overflow_flag,
	output logic wake_request
);
	import ctu_pkg::*;

	logic ext_level;
	logic sync1_q;
	logic sync2_q;
	logic sync3_q;
	logic raw_q;
	logic raw_prev_q;
	logic sync_edge;
	logic raw_edge;
	logic ext_edge;
	logic src_tick;
	logic run_allowed;
	logic wr_any;
	logic psc_tick;
	logic [15:0] count_q;
	logic [15:0] count_d;
	logic wrap;
	logic overflow_q;
	logic osc_drive_q;
	logic [7:0] high_q;
	logic [7:0] low_q;
	logic wake_q;

	// External source: the crystal when the oscillator runs, else the clock pin
	assign ext_level = ctrl.secondary_osc_enable ? crystal_input_pin : ext_clk_pin;

	// Two-stage synchroniser plus one stage for edge detection
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			sync3_q <= 1'b0;
		end else begin
			sync1_q <= ext_level;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	// Short path that bypasses the synchroniser in unsynchronised mode
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			raw_q <= 1'b0;
			raw_prev_q <= 1'b0;
		end else begin
			raw_q <= ext_level;
			raw_prev_q <= raw_q;
		end
	end

	assign sync_edge = sync2_q && !sync3_q;
	assign raw_edge = raw_q && !raw_prev_q;
	// Paths differ by one cycle, so a switch can drop or repeat one edge
	assign ext_edge = ctrl.unsync_mode ? raw_edge : sync_edge;

	// Internal source ticks every core cycle but is frozen by sleep
	assign src_tick = ctrl.ext_source ? ext_edge : 1'b1;

	// Sleep stops all counting except unsynchronised external counting
	assign run_allowed = ctrl.timer_on &&
		(!sleep_mode || (ctrl.unsync_mode && ctrl.ext_source));

	assign wr_any = wr.wr_high || wr.wr_low;

	ctu_prescaler u_prescaler (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_in(src_tick && run_allowed),
		.clear(wr_any),
		.prescale_select(ctrl.prescale_select),
		.tick_out(psc_tick)
	);

	// Next count; a byte write beats a same-cycle increment
	always_comb begin
		count_d = count_q;
		if (wr_any) begin
			if (wr.wr_high) begin
				count_d[15:8] = wr.data;
			end
			if (wr.wr_low) begin
				count_d[7:0] = wr.data;
			end
		end else if (psc_tick) begin
			count_d = count_q + CTU_CNT_ONE;
		end
	end

	assign wrap = !wr_any && psc_tick && (count_q == CTU_CNT_MAX);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= CTU_CNT_RST;
		end else begin
			count_q <= count_d;
		end
	end

	// Sticky overflow flag; a wrap in the clearing cycle keeps it set
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			overflow_q <= 1'b0;
		end else if (wrap) begin
			overflow_q <= 1'b1;
		end else if (overflow_clear) begin
			overflow_q <= 1'b0;
		end
	end

	assign overflow_flag = overflow_q;

	// Byte registers mirror the count each cycle, so a read never sees a torn value
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			high_q <= CTU_CNT_RST[15:8];
			low_q <= CTU_CNT_RST[7:0];
		end else begin
			high_q <= count_q[15:8];
			low_q <= count_q[7:0];
		end
	end

	assign count_high_byte = high_q;
	assign count_low_byte = low_q;

	// Inverting amplifier; sleep is not a term, so the crystal keeps swinging
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_drive_q <= 1'b0;
		end else begin
			osc_drive_q <= ctrl.secondary_osc_enable && !crystal_input_pin;
		end
	end

	assign crystal_drive_pin = osc_drive_q;

	// Wake request: overflow while asleep, held until sleep ends
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else if (!sleep_mode) begin
			wake_q <= 1'b0;
		end else if (wrap) begin
			wake_q <= 1'b1;
		end
	end

	assign wake_request = wake_q;

endmodule

`default_nettype wire

// file: ctu_timer_monitor.sv
// Port-level checker for the counter unit, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module ctu_timer_monitor (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire ctu_pkg::ctu_ctrl_s ctrl,
	input wire ctu_pkg::ctu_wr_s wr,
	input wire logic overflow_clear,
	input wire logic sleep_mode,
	input wire logic crystal_input_pin,
	input wire logic crystal_drive_pin,
	input wire logic [7:0] count_high_byte,
	input wire logic [7:0] count_low_byte,
	input wire logic overflow_flag
);
	import ctu_pkg::*;
	// Byte outputs lag the counter by one edge, so conditions span several cycles
	wire logic [15:0] cnt = {count_high_byte, count_low_byte};
	wire logic nowr = !wr.wr_high && !wr.wr_low;
	wire logic run1 = ctrl.timer_on && !ctrl.ext_source && !sleep_mode && nowr
		&& ctrl.prescale_select == CTU_DIV1;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_div1; run1 [*3] |=> cnt == $past(cnt) + 16'h0001; endproperty
	a_div1: assert property (p_div1) else $error("no single step");
	property p_hold; (!ctrl.timer_on && nowr) [*2] |=> $stable(cnt); endproperty
	a_hold: assert property (p_hold) else $error("count moved while off");
	property p_sleep; (sleep_mode && !ctrl.unsync_mode && nowr) [*2] |=> $stable(cnt); endproperty
	a_sleep: assert property (p_sleep) else $error("count moved in sleep");
	property p_wlow; (wr.wr_low && !ctrl.timer_on) ##1 (!ctrl.timer_on && !wr.wr_low)
		|=> count_low_byte == $past(wr.data, 2); endproperty
	a_wlow: assert property (p_wlow) else $error("low byte write lost");
	property p_wrap; $rose(overflow_flag) |-> cnt == CTU_CNT_MAX; endproperty
	a_wrap: assert property (p_wrap) else $error("flag without wrap");
	property p_stick; overflow_flag && !overflow_clear |=> overflow_flag; endproperty
	a_stick: assert property (p_stick) else $error("flag dropped");
	property p_clear; overflow_clear && !ctrl.timer_on |=> !overflow_flag; endproperty
	a_clear: assert property (p_clear) else $error("flag not cleared");
	property p_osc; $past(rst_n) |-> crystal_drive_pin
		== $past(ctrl.secondary_osc_enable && !crystal_input_pin); endproperty
	a_osc: assert property (p_osc) else $error("amplifier wrong");
endmodule
bind ctu_timer ctu_timer_monitor mon (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl), .wr(wr),
	.overflow_clear(overflow_clear), .sleep_mode(sleep_mode),
	.crystal_input_pin(crystal_input_pin), .crystal_drive_pin(crystal_drive_pin),
	.count_high_byte(count_high_byte), .count_low_byte(count_low_byte),
	.overflow_flag(overflow_flag));
`default_nettype wire

// file: ctu_xtal_model.sv
// Behavioural crystal on the oscillator pins
`timescale 1ns/1ps
`default_nettype none
module ctu_xtal_model #(
	parameter int HALF = 4
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic drive,
	output logic pin
);
	int cnt_q;
	// Node follows the amplifier once per half period; with no drive it settles low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 0;
			pin <= 1'b0;
		end else if (cnt_q == HALF - 1) begin
			cnt_q <= 0;
			pin <= drive;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench of the counter unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ctu_pkg::*;
	logic core_clk, rst_n, clr, slp, xin, xdrv, ovf, wake, ext;
	logic [7:0] hb, lb;
	logic [15:0] v;
	ctu_ctrl_s ctrl;
	ctu_wr_s wr;
	int miscompares, check_count, n;
	ctu_timer dut (.core_clk(core_clk), .rst_n(rst_n), .ctrl(ctrl), .wr(wr),
		.overflow_clear(clr), .sleep_mode(slp), .ext_clk_pin(ext),
		.crystal_input_pin(xin), .crystal_drive_pin(xdrv), .count_high_byte(hb),
		.count_low_byte(lb), .overflow_flag(ovf), .wake_request(wake));
	ctu_xtal_model xtal (.core_clk(core_clk), .rst_n(rst_n), .drive(xdrv), .pin(xin));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask
	// Strobe bit 1 is the high byte, bit 0 the low byte; only called while stopped
	task automatic wbyte(input logic [1:0] s, input logic [7:0] d);
		@(negedge core_clk) wr = {s, d};
		@(negedge core_clk) wr = '0;
	endtask
	task automatic run(input int k);
		ctrl.timer_on = 1'b1;
		cyc(k);
		ctrl.timer_on = 1'b0;
	endtask
	// Count k rising edges on the clock pin from zero; pin holds three cycles per level
	task automatic ext_edges(input ctu_ctrl_s c, input int k);
		wbyte(2'h3, 8'h00);
		ctrl = c;
		repeat (2 * k) begin
			cyc(3);
			ext = ~ext;
		end
		ctrl.timer_on = 1'b0;
		cyc(2);
	endtask
	initial begin
		rst_n = 1'b0;
		ctrl = '0;
		wr = '0;
		clr = 1'b0;
		slp = 1'b0;
		ext = 1'b0;
		miscompares = 0;
		check_count = 0;
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		chk({hb, lb}, 16'h0000);
		// One tick from all ones must wrap and raise the flag
		wbyte(2'h3, 8'hff);
		run(1);
		cyc(2);
		chk({hb, lb}, 16'h0000);
		chk({15'h0, ovf}, 16'h0001);
		@(negedge core_clk) clr = 1'b1;
		@(negedge core_clk) clr = 1'b0;
		chk({15'h0, ovf}, 16'h0000);
		// Short runs leave a partial prescale count that a write must discard
		for (int s = 0; s < 4; s++) begin
			ctrl.prescale_select = 2'(s);
			wbyte(2'h3, 8'h00);
			run((4 << s) - 1);
			cyc(2);
			chk({hb, lb}, 16'h0003);
			wbyte(2'h1, 8'h00);
			run((2 << s) - 1);
			cyc(2);
			chk({hb, lb}, 16'h0001);
		end
		// Start-up wait on the crystal while asleep, unsynchronised
		wbyte(2'h2, 8'hfc);
		wbyte(2'h1, 8'h00);
		ctrl = '{1'b1, CTU_DIV1, 1'b1, 1'b1, 1'b1};
		slp = 1'b1;
		for (n = 0; n < 9000 && ovf !== 1'b1; n++) cyc(1);
		chk({15'h0, ovf}, 16'h0001);
		if (ovf !== 1'b1) tally_and_finish();
		chk(16'(n > 8000), 16'h0001);
		cyc(2);
		chk({15'h0, wake}, 16'h0001);
		// Synchronised counting must stop in sleep
		ctrl.unsync_mode = 1'b0;
		cyc(4);
		v = {hb, lb}; // Both bytes taken in one sample, so no wrap between them
		cyc(64);
		chk({hb, lb}, v);
		slp = 1'b0;
		ctrl = '0;
		cyc(20);
		chk({14'h0, wake, xdrv}, 16'h0000);
		// Clock pin counted through the synchroniser, divided by two, then unsynchronised
		ext_edges('{1'b1, CTU_DIV2, 1'b0, 1'b0, 1'b1}, 10);
		chk({hb, lb}, 16'h0005);
		ext_edges('{1'b1, CTU_DIV1, 1'b0, 1'b1, 1'b1}, 10);
		chk({hb, lb}, 16'h000a);
		tally_and_finish();
	end
endmodule
`default_nettype wire
